// ---- design/aea_pkg.sv ----
package aea_pkg;
  localparam int RMS_W          = 24;
  localparam int PWR_W          = 24;
  localparam int TOT_W          = PWR_W + 2;
  localparam int ACC_W          = 41;
  localparam int OUT_W          = 16;
  localparam int GAIN_W         = 12;
  localparam int DIV_W          = 8;
  localparam int FD_W           = 12;
  localparam int ZC_W           = 16;
  localparam int DFC_W          = 32;
  localparam int ACC_PERIOD_CYC = 4;

  localparam logic [7:0] OFS_COMPENSATION_MODE_REG = 8'h00;
  localparam logic [7:0] OFS_WAVEFORM_MODE_REG  = 8'h04;
  localparam logic [7:0] OFS_LINE_CYCLE_MODE_REG = 8'h08;
  localparam logic [7:0] OFS_ZCCOUNT  = 8'h0c;
  localparam logic [7:0] OFS_DIVIDER  = 8'h10;
  localparam logic [7:0] OFS_NUM      = 8'h14;
  localparam logic [7:0] OFS_DEN      = 8'h18;
  localparam logic [7:0] OFS_MASK     = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_ENERGY   = 8'h24;
  localparam logic [7:0] OFS_GAIN     = 8'h30;
  localparam logic [7:0] OFS_APPARENT_GAIN_TRIM   = 8'h3c;
  localparam logic [7:0] WORD_STEP    = 8'h04;

  localparam int CONN_LSB   = 0;
  localparam int INC_LSB    = 2;
  localparam int PSRC_BIT   = 7;
  localparam int LC_ACT_BIT = 0;
  localparam int LC_REA_BIT = 1;
  localparam int LC_APP_BIT = 2;
  localparam int RDCLR_BIT  = 6;
  localparam int HALF_BIT   = 2;
  localparam int IG_LSB     = 0;
  localparam int VG_LSB     = 12;

  localparam logic [1:0] CONN_TWO      = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;
  localparam logic [GAIN_W:0] GAIN_ONE = 13'h1000;
endpackage

// ---- design/aea_phase_acc.sv ----
module aea_phase_acc (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       tick,
  input  wire logic                       clear,
  input  wire logic [aea_pkg::PWR_W-1:0]  power,
  input  wire logic [aea_pkg::DIV_W-1:0]  divider,
  output logic      [aea_pkg::ACC_W-1:0]  acc_value
);
  import aea_pkg::*;

  logic [PWR_W-1:0] q;
  logic [ACC_W-1:0] acc_reg;

  // Divide before accumulation; 0 and 1 both mean no division
  always_comb begin
    if (divider > 8'h01) begin
      q = power / {{(PWR_W-DIV_W){1'b0}}, divider};
    end else begin
      q = power;
    end
  end

  // Clear keeps this period's sample so nothing is lost at restart
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_reg <= '0;
    end else if (clear) begin
      acc_reg <= tick ? {{(ACC_W-PWR_W){1'b0}}, q} : '0;
    end else if (tick) begin
      acc_reg <= acc_reg + {{(ACC_W-PWR_W){1'b0}}, q};
    end
  end

  assign acc_value = acc_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_acc_add: assert property (tick && !clear |=>
    acc_reg == $past(acc_reg) + {{(ACC_W-PWR_W){1'b0}}, $past(q)})
    else $error("accumulator did not add sample");
  a_div_pass: assert property (divider <= 8'h01 |-> q == power)
    else $error("divider 0 or 1 altered power");
endmodule // aea_phase_acc

// ---- design/aea_dfc.sv ----
module aea_dfc #(
  parameter logic [aea_pkg::DFC_W-1:0] THRESH = 32'h0100_0000,
  parameter int                        HOLD   = 4
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      tick,
  input  wire logic [aea_pkg::TOT_W-1:0] total,
  input  wire logic [aea_pkg::FD_W-1:0]  num,
  input  wire logic [aea_pkg::FD_W-1:0]  den,
  input  wire logic                      src_apparent,
  input  wire logic                      reactive_pulse,
  output logic                           pulse_out
);
  import aea_pkg::*;

  logic [DFC_W-1:0] acc_reg;
  logic [DFC_W-1:0] acc_next;
  logic             int_pulse;
  logic [FD_W:0]    frac_reg;
  logic [FD_W:0]    frac_next;
  logic [FD_W-1:0]  num_eff;
  logic [FD_W-1:0]  den_eff;
  logic [7:0]       hold_reg;

  assign acc_next  = acc_reg + {{(DFC_W-TOT_W){1'b0}}, total};
  assign int_pulse = tick && (acc_next >= THRESH);
  assign num_eff   = (num == '0) ? 12'h001 : num;
  assign den_eff   = (den == '0) ? 12'h001 : den;
  assign frac_next = frac_reg + {1'b0, num_eff};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_reg <= '0;
    end else if (int_pulse) begin
      acc_reg <= acc_next - THRESH;
    end else if (tick) begin
      acc_reg <= acc_next;
    end
  end

  // One output pulse per den/num converter pulses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frac_reg <= '0;
      hold_reg <= '0;
    end else if (int_pulse && frac_next >= {1'b0, den_eff}) begin
      frac_reg <= frac_next - {1'b0, den_eff};
      hold_reg <= 8'(HOLD);
    end else begin
      if (int_pulse) begin
        frac_reg <= frac_next;
      end
      if (hold_reg != '0) begin
        hold_reg <= hold_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= src_apparent ? (hold_reg != '0) : reactive_pulse;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_src_mux: assert property (##1 pulse_out ==
    ($past(src_apparent) ? ($past(hold_reg) != '0) : $past(reactive_pulse)))
    else $error("pulse output shows wrong source");
endmodule // aea_dfc

// ---- design/aea_top.sv ----
// What this block does
// - Adds each phase's apparent power into its accumulator every four clock cycles.
// - Readable energy is 16 bits; internal accumulator overflows past 0x1FF_FFFF_FFFF.
// - A divider above 1 lengthens time to overflow in proportion to its value.
// - Connection codes 00 and 10: each phase uses its own voltage and current.
// - Code 01: phase B uses mean of A and C voltage times B current.
// - Current gain, voltage rms gain and apparent gain all scale each phase.
// - Pulse source bit 7 switches the second pulse output to apparent power.
// - A digital-to-frequency converter makes the pulses; numerator and denominator scale.
// - Include bits 2 to 4 add phases A, B, C into the total.
// - The second pulse output carries only one quantity at a time.
// - Line-cycle bit 2 latches energy summed over the zero-crossing count.
// - Active and reactive line-cycle bits share the same zero-crossing period.
// - One output pulse per denominator-over-numerator converter pulses.
// - Accumulators are 41-bit unsigned; readable registers show their upper 16 bits.
// - Eight-bit divider divides power first; 0 or 1 means no division.
// - With mask bit 2, a change of any energy MSB raises the interrupt.
module aea_top #(
  parameter logic [aea_pkg::DFC_W-1:0] DFC_THRESH = 32'h0100_0000,
  parameter int                        PULSE_HOLD = 4
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic      [31:0]               hrdata,
  input  wire logic [aea_pkg::RMS_W-1:0] phase_a_voltage_rms,
  input  wire logic [aea_pkg::RMS_W-1:0] phase_b_voltage_rms,
  input  wire logic [aea_pkg::RMS_W-1:0] phase_c_voltage_rms,
  input  wire logic [aea_pkg::RMS_W-1:0] phase_a_current_rms,
  input  wire logic [aea_pkg::RMS_W-1:0] phase_b_current_rms,
  input  wire logic [aea_pkg::RMS_W-1:0] phase_c_current_rms,
  input  wire logic                      zero_cross_in,
  input  wire logic                      reactive_pulse_in,
  output logic                           second_pulse_output,
  output logic                           line_cycle_done,
  output logic                           active_line_cycle_enable,
  output logic                           reactive_line_cycle_enable,
  output logic                           half_full_irq
);
  import aea_pkg::*;

  logic [4:0]        compensation_mode_reg;
  logic              pulse_source_select;
  logic [7:0]        line_cycle_mode_reg;
  logic [ZC_W-1:0]   zero_crossing_count;
  logic [DIV_W-1:0]  apparent_energy_divider;
  logic [FD_W-1:0]   pulse_divider_numerator;
  logic [FD_W-1:0]   pulse_divider_denominator;
  logic              apparent_half_full_mask;
  logic              half_full_status_reg;
  logic [23:0]       gain_reg [3];
  logic [GAIN_W-1:0] apparent_gain_trim [3];

  logic              accept;
  logic              wr_pend_reg;
  logic [7:0]        wr_addr_reg;
  logic [31:0]       rd_data;
  logic [RMS_W-1:0]  vrms [3];
  logic [RMS_W-1:0]  irms [3];
  logic [RMS_W-1:0]  vg [3];
  logic [RMS_W-1:0]  ig [3];
  logic [RMS_W-1:0]  v_sel [3];
  logic [PWR_W-1:0]  power [3];
  logic [TOT_W-1:0]  total_pwr;
  logic [1:0]        conn;
  logic [1:0]        tick_cnt_reg;
  logic              tick;
  logic [ACC_W-1:0]  acc_val [3];
  logic [2:0]        acc_clr;
  logic [OUT_W-1:0]  energy_hold_reg [3];
  logic [OUT_W-1:0]  energy_out [3];
  logic [ZC_W-1:0]   zc_cnt_reg;
  logic [ZC_W-1:0]   zc_target;
  logic              lc_any;
  logic              apparent_line_cycle_enable;
  logic              lc_hit;
  logic              rd_clr;
  logic [2:0]        msb_prev_reg;
  logic              msb_change;

  // Scale by (1 + g / 4096); clips instead of wrapping on +50%
  function automatic logic [RMS_W-1:0] gain_apply(input logic [RMS_W-1:0]  x,
                                                  input logic [GAIN_W-1:0] g);
    logic [GAIN_W:0]          k;
    logic [RMS_W+GAIN_W:0]    t;
    k = GAIN_ONE + {g[GAIN_W-1], g};
    t = {{(GAIN_W+1){1'b0}}, x} * {{RMS_W{1'b0}}, k};
    return t[RMS_W+GAIN_W] ? '1 : t[RMS_W+GAIN_W-1:GAIN_W];
  endfunction

  function automatic logic [PWR_W-1:0] pwr_mul(input logic [RMS_W-1:0] v,
                                               input logic [RMS_W-1:0] i);
    logic [2*RMS_W-1:0] t;
    t = {{RMS_W{1'b0}}, v} * {{RMS_W{1'b0}}, i};
    return t[2*RMS_W-1:RMS_W];
  endfunction

  function automatic logic [RMS_W-1:0] avg2(input logic [RMS_W-1:0] a,
                                            input logic [RMS_W-1:0] b);
    logic [RMS_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[RMS_W:1];
  endfunction

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign accept    = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= accept && hwrite;
      if (accept) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      compensation_mode_reg     <= '0;
      pulse_source_select       <= 1'b0;
      line_cycle_mode_reg       <= '0;
      zero_crossing_count       <= '0;
      apparent_energy_divider   <= '0;
      pulse_divider_numerator   <= '0;
      pulse_divider_denominator <= '0;
      apparent_half_full_mask   <= 1'b0;
      for (int p = 0; p < 3; p++) begin
        gain_reg[p]           <= '0;
        apparent_gain_trim[p] <= '0;
      end
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        OFS_COMPENSATION_MODE_REG: compensation_mode_reg     <= hwdata[4:0];
        OFS_WAVEFORM_MODE_REG:  pulse_source_select       <= hwdata[PSRC_BIT];
        OFS_LINE_CYCLE_MODE_REG: line_cycle_mode_reg       <= hwdata[7:0];
        OFS_ZCCOUNT:  zero_crossing_count       <= hwdata[ZC_W-1:0];
        OFS_DIVIDER:  apparent_energy_divider   <= hwdata[DIV_W-1:0];
        OFS_NUM:      pulse_divider_numerator   <= hwdata[FD_W-1:0];
        OFS_DEN:      pulse_divider_denominator <= hwdata[FD_W-1:0];
        OFS_MASK:     apparent_half_full_mask   <= hwdata[HALF_BIT];
        default: begin
          for (int p = 0; p < 3; p++) begin
            if (wr_addr_reg == OFS_GAIN + 8'(p * 4)) begin
              gain_reg[p] <= hwdata[23:0];
            end
            if (wr_addr_reg == OFS_APPARENT_GAIN_TRIM + 8'(p * 4)) begin
              apparent_gain_trim[p] <= hwdata[GAIN_W-1:0];
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    rd_data = '0;
    unique case (haddr[7:0])
      OFS_COMPENSATION_MODE_REG: rd_data[4:0]        = compensation_mode_reg;
      OFS_WAVEFORM_MODE_REG:  rd_data[PSRC_BIT]   = pulse_source_select;
      OFS_LINE_CYCLE_MODE_REG: rd_data[7:0]        = line_cycle_mode_reg;
      OFS_ZCCOUNT:  rd_data[ZC_W-1:0]   = zero_crossing_count;
      OFS_DIVIDER:  rd_data[DIV_W-1:0]  = apparent_energy_divider;
      OFS_NUM:      rd_data[FD_W-1:0]   = pulse_divider_numerator;
      OFS_DEN:      rd_data[FD_W-1:0]   = pulse_divider_denominator;
      OFS_MASK:     rd_data[HALF_BIT]   = apparent_half_full_mask;
      OFS_STATUS:   rd_data[HALF_BIT]   = half_full_status_reg;
      default: begin
        for (int p = 0; p < 3; p++) begin
          if (haddr[7:0] == OFS_ENERGY + 8'(p * 4)) begin
            rd_data[OUT_W-1:0] = energy_out[p];
          end
          if (haddr[7:0] == OFS_GAIN + 8'(p * 4)) begin
            rd_data[23:0] = gain_reg[p];
          end
          if (haddr[7:0] == OFS_APPARENT_GAIN_TRIM + 8'(p * 4)) begin
            rd_data[GAIN_W-1:0] = apparent_gain_trim[p];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= '0;
    end else begin
      hrdata <= (accept && !hwrite) ? rd_data : '0;
    end
  end

  // Power path
  assign conn    = compensation_mode_reg[CONN_LSB+1:CONN_LSB];
  assign vrms[0] = phase_a_voltage_rms;
  assign vrms[1] = phase_b_voltage_rms;
  assign vrms[2] = phase_c_voltage_rms;
  assign irms[0] = phase_a_current_rms;
  assign irms[1] = phase_b_current_rms;
  assign irms[2] = phase_c_current_rms;

  always_comb begin
    total_pwr = '0;
    for (int p = 0; p < 3; p++) begin
      vg[p] = gain_apply(vrms[p], gain_reg[p][VG_LSB+GAIN_W-1:VG_LSB]);
      ig[p] = gain_apply(irms[p], gain_reg[p][IG_LSB+GAIN_W-1:IG_LSB]);
    end
    v_sel[0] = vg[0];
    v_sel[2] = vg[2];
    // Reserved code 11 behaves as 00
    v_sel[1] = (conn == CONN_TWO) ? avg2(vg[0], vg[2]) : vg[1];
    for (int p = 0; p < 3; p++) begin
      power[p] = gain_apply(pwr_mul(v_sel[p], ig[p]), apparent_gain_trim[p]);
      if (compensation_mode_reg[INC_LSB+p]) begin
        total_pwr = total_pwr + {2'b00, power[p]};
      end
    end
  end

  // Accumulation period strobe
  always_ff @(posedge clk) begin
    if (!reset_n || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 2'h1;
    end
  end
  assign tick = (tick_cnt_reg == 2'(ACC_PERIOD_CYC - 1));

  // Line-cycle period, shared by all three energy types
  assign apparent_line_cycle_enable       = line_cycle_mode_reg[LC_APP_BIT];
  assign lc_any    = |line_cycle_mode_reg[LC_APP_BIT:LC_ACT_BIT];
  assign zc_target = (zero_crossing_count == '0) ? 16'h0001 : zero_crossing_count;
  assign lc_hit    = lc_any && zero_cross_in &&
                     ({1'b0, zc_cnt_reg} + 17'h00001 >= {1'b0, zc_target});

  always_ff @(posedge clk) begin
    if (!reset_n || !lc_any || lc_hit) begin
      zc_cnt_reg <= '0;
    end else if (zero_cross_in) begin
      zc_cnt_reg <= zc_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_cycle_done            <= 1'b0;
      active_line_cycle_enable   <= 1'b0;
      reactive_line_cycle_enable <= 1'b0;
    end else begin
      line_cycle_done            <= lc_hit;
      active_line_cycle_enable   <= line_cycle_mode_reg[LC_ACT_BIT];
      reactive_line_cycle_enable <= line_cycle_mode_reg[LC_REA_BIT];
    end
  end

  // Read-clear only outside line-cycle mode, where it would corrupt periods
  assign rd_clr = accept && !hwrite && line_cycle_mode_reg[RDCLR_BIT] && !apparent_line_cycle_enable;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign acc_clr[p] = (lc_hit && apparent_line_cycle_enable) ||
                        (rd_clr && haddr[7:0] == OFS_ENERGY + 8'(p * 4));
    aea_phase_acc u_acc (
      .clk       (clk),
      .reset_n   (reset_n),
      .tick      (tick),
      .clear     (acc_clr[p]),
      .power     (power[p]),
      .divider   (apparent_energy_divider),
      .acc_value (acc_val[p])
    );
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        energy_hold_reg[p] <= '0;
      end else if (lc_hit && apparent_line_cycle_enable) begin
        energy_hold_reg[p] <= acc_val[p][ACC_W-1:ACC_W-OUT_W];
      end
    end
    assign energy_out[p] = apparent_line_cycle_enable ? energy_hold_reg[p] : acc_val[p][ACC_W-1:ACC_W-OUT_W];
  end

  // Half-full event; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      msb_prev_reg <= '0;
    end else begin
      msb_prev_reg <= {energy_out[2][OUT_W-1], energy_out[1][OUT_W-1], energy_out[0][OUT_W-1]};
    end
  end
  assign msb_change = |(msb_prev_reg ^
                        {energy_out[2][OUT_W-1], energy_out[1][OUT_W-1], energy_out[0][OUT_W-1]});

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      half_full_status_reg <= 1'b0;
      half_full_irq        <= 1'b0;
    end else begin
      if (msb_change) begin
        half_full_status_reg <= 1'b1;
      end else if (wr_pend_reg && wr_addr_reg == OFS_STATUS && hwdata[HALF_BIT]) begin
        half_full_status_reg <= 1'b0;
      end
      half_full_irq <= half_full_status_reg && apparent_half_full_mask;
    end
  end

  aea_dfc #(
    .THRESH (DFC_THRESH),
    .HOLD   (PULSE_HOLD)
  ) u_dfc (
    .clk            (clk),
    .reset_n        (reset_n),
    .tick           (tick),
    .total          (total_pwr),
    .num            (pulse_divider_numerator),
    .den            (pulse_divider_denominator),
    .src_apparent   (pulse_source_select),
    .reactive_pulse (reactive_pulse_in),
    .pulse_out      (second_pulse_output)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_tick_gap;
    !tick [*3] ##1 tick;
  endsequence

  a_tick_period: assert property (tick |=> s_tick_gap)
    else $error("accumulation period is not four cycles");
  a_conn_avg: assert property (conn == CONN_TWO |-> v_sel[1] == avg2(vg[0], vg[2]))
    else $error("phase B voltage is not the A-C mean");
  a_conn_own: assert property (conn != CONN_TWO |-> v_sel[1] == vg[1])
    else $error("phase B voltage is not its own");
  a_total_none: assert property (compensation_mode_reg[INC_LSB+2:INC_LSB] == 3'h0
    |-> total_pwr == '0)
    else $error("excluded phases reached the total");
  a_lc_latch: assert property (lc_hit && apparent_line_cycle_enable |=>
    energy_hold_reg[1] == $past(acc_val[1][ACC_W-1:ACC_W-OUT_W]))
    else $error("line-cycle result not latched");
  a_lc_restart: assert property (lc_hit && apparent_line_cycle_enable && !tick |=> acc_val[0] == '0)
    else $error("accumulator not restarted after line cycle");
  a_half_set: assert property (msb_change |=> half_full_status_reg ##1
    (half_full_irq == $past(apparent_half_full_mask)))
    else $error("half-full event lost");
  a_live_view: assert property (!apparent_line_cycle_enable |-> energy_out[2] == acc_val[2][ACC_W-1:ACC_W-OUT_W])
    else $error("readable energy is not upper accumulator bits");
  a_unity_gain: assert property (gain_reg[0] == '0 && apparent_gain_trim[0] == '0
    |-> power[0] == pwr_mul(vrms[0], irms[0]))
    else $error("zero gains changed phase A power");
  a_done_pulse: assert property (lc_hit |=> line_cycle_done ##1 !line_cycle_done)
    else $error("line-cycle done not a single pulse");
endmodule // aea_top

// ---- sim/aea_host_model.sv ----
module aea_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import aea_pkg::*;

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Single word transfer; waits on hready with no fixed latency assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    // Read cycles carry a changing pattern so stale data cannot pass
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // aea_host_model

// ---- sim/tb_apparent_energy_accumulator.sv ----
module tb_apparent_energy_accumulator;
  timeunit 1ns;
  timeprecision 1ps;
  import aea_pkg::*;

  logic             clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic      [31:0] haddr, hwdata, hrdata;
  logic      [1:0]  htrans;
  logic      [2:0]  hsize;
  logic      [23:0] va, vb, vc, ia, ib, ic;
  logic             zero_cross_in, reactive_pulse_in, spo, done, ale, rle, seen, irq;
  int               num_errors, check_count, hi;

  aea_host_model i_aea_host_model (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  aea_top #(.DFC_THRESH(32'h0000_0100)) i_aea_top (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .phase_a_voltage_rms(va), .phase_b_voltage_rms(vb), .phase_c_voltage_rms(vc),
    .phase_a_current_rms(ia), .phase_b_current_rms(ib), .phase_c_current_rms(ic),
    .zero_cross_in(zero_cross_in), .reactive_pulse_in(reactive_pulse_in),
    .second_pulse_output(spo), .line_cycle_done(done), .active_line_cycle_enable(ale),
    .reactive_line_cycle_enable(rle), .half_full_irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_aea_host_model.xfer(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    i_aea_host_model.xfer(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask

  // Two 256-cycle periods: the first is discarded, the second holds 64 whole ticks
  task automatic measure(input logic [31:0] cm, dv, ga, ea, eb, ec);
    wr(OFS_COMPENSATION_MODE_REG, cm);
    wr(OFS_DIVIDER, dv);
    wr(OFS_APPARENT_GAIN_TRIM, ga);
    repeat (2) begin
      repeat (255) @(posedge clk);
      zero_cross_in <= 1'b1;
      @(posedge clk);
      zero_cross_in <= 1'b0;
    end
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk);
      seen = seen | done;
    end
    check({31'h0, seen}, 32'h1);
    rd_chk(OFS_ENERGY, ea);
    rd_chk(OFS_ENERGY + WORD_STEP, eb);
    rd_chk(OFS_ENERGY + 8'h08, ec);
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #300us;
    num_errors++;
    close_out();
  end

  initial begin
    {va, vb, vc, ia, ib, ic} = '0;
    {zero_cross_in, reactive_pulse_in} = 2'b00;
    num_errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_GAIN, 32'h0);
    rd_chk(OFS_WAVEFORM_MODE_REG, 32'h0);
    rd_chk(8'hfc, 32'h0);
    wr(OFS_ENERGY, 32'hffff);
    rd_chk(OFS_ENERGY, 32'h0);
    wr(OFS_DIVIDER, 32'h1ff);
    rd_chk(OFS_DIVIDER, 32'hff);
    // Mask on, so any stray half-full event would show on the pin
    wr(OFS_MASK, 32'h4);
    rd_chk(OFS_STATUS, 32'h0);
    va <= 24'h800000;
    vb <= 24'h200000;
    vc <= 24'h400000;
    {ia, ib, ic} <= {3{24'h800000}};
    wr(OFS_ZCCOUNT, 32'h1);
    // Read-clears stays off; current gain is never written
    wr(OFS_LINE_CYCLE_MODE_REG, 32'h7);
    // Enable copies are registered one edge after the write lands
    repeat (2) @(posedge clk);
    check({30'h0, ale, rle}, 32'h3);
    measure(32'h0, 32'h0, 32'h0, 32'h8, 32'h2, 32'h4);
    measure(32'h1, 32'h0, 32'h0, 32'h8, 32'h6, 32'h4);
    measure(32'h2, 32'h0, 32'h0, 32'h8, 32'h2, 32'h4);
    measure(32'h3, 32'h0, 32'h0, 32'h8, 32'h2, 32'h4);
    measure(32'h0, 32'h1, 32'h0, 32'h8, 32'h2, 32'h4);
    measure(32'h0, 32'h2, 32'h0, 32'h4, 32'h1, 32'h2);
    measure(32'h0, 32'h0, 32'h800, 32'h4, 32'h2, 32'h4);
    reactive_pulse_in <= 1'b1;
    repeat (3) @(posedge clk);
    check({31'h0, spo}, 32'h1);
    wr(OFS_WAVEFORM_MODE_REG, 32'h80);
    repeat (8) @(posedge clk);
    seen = 1'b0;
    repeat (64) begin
      @(posedge clk);
      seen = seen | spo;
    end
    check({31'h0, seen}, 32'h0);
    wr(OFS_NUM, 32'h1);
    wr(OFS_DEN, 32'h1);
    wr(OFS_COMPENSATION_MODE_REG, 32'h4);
    seen = 1'b0;
    repeat (64) begin
      @(posedge clk);
      seen = seen | spo;
    end
    check({31'h0, seen}, 32'h1);
    // One output pulse per two converter pulses: high half of the time
    wr(OFS_DEN, 32'h2);
    repeat (16) @(posedge clk);
    hi = 0;
    repeat (64) begin
      @(posedge clk);
      hi += spo;
    end
    check(hi, 32'h20);
    // Energy MSBs never move in this run, so no event and an OKAY bus
    check({30'h0, hresp, irq}, 32'h0);
    close_out();
  end
endmodule // tb_apparent_energy_accumulator
